// ### core/psg_port_clock_gate.sv
// APB register file and port clock gating for five general-purpose ports
`timescale 1ns/1ps
module psg_port_clock_gate
	import psg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PSG_ADDR_W-1:0] paddr,
	input wire logic [PSG_DATA_W-1:0] pwdata,
	output logic [PSG_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power mode from the system controller
	input wire logic sleep_now,
	input wire logic deep_sleep_now,
	// Port clock enables, bit 0 port A
	output logic [PSG_PORTS-1:0] port_clk_en,
	// Accesses aimed at the ports
	input wire logic port_req,
	input wire logic [PSG_PORTS-1:0] port_req_sel,
	output logic port_req_ok,
	output logic port_req_fault
);
	psg_gate_if gif ();

	psg_gate_t run_ff, nxt_run;
	psg_gate_t sleep_ff, nxt_sleep;
	psg_gate_t deep_ff, nxt_deep;
	logic auto_ff, nxt_auto;
	logic [PSG_DATA_W-1:0] rdata_ff, nxt_rdata;
	logic err_ff, nxt_err;
	logic ok_ff, nxt_ok;
	logic fault_ff, nxt_fault;
	logic setup;
	logic wr_acc;

	////////////////////////////////////////////////////////////////////////////
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;

	always_comb
	begin
		nxt_run = run_ff;
		nxt_sleep = sleep_ff;
		nxt_deep = deep_ff;
		nxt_auto = auto_ff;
		nxt_rdata = rdata_ff;
		nxt_err = err_ff;
		// Decode during setup so read data leaves a flop in the access phase
		if (setup)
		begin
			nxt_rdata = PSG_ZERO;
			nxt_err = 1'b0;
			if (paddr == PSG_OFS_DEEP_GATE)
				nxt_rdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A] = deep_ff;
			else if (paddr == PSG_OFS_SLEEP_GATE)
				nxt_rdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A] = sleep_ff;
			else if (paddr == PSG_OFS_RUN_GATE)
				nxt_rdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A] = run_ff;
			else if (paddr == PSG_OFS_RUN_CFG)
				nxt_rdata[PSG_BIT_AUTO] = auto_ff;
			else
				nxt_err = 1'b1;
		end
		// Upper write bits are dropped, the gate fields are only five wide and the auto field one
		if (wr_acc)
		begin
			if (paddr == PSG_OFS_DEEP_GATE)
				nxt_deep = pwdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A];
			else if (paddr == PSG_OFS_SLEEP_GATE)
				nxt_sleep = pwdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A];
			else if (paddr == PSG_OFS_RUN_GATE)
				nxt_run = pwdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A];
			else if (paddr == PSG_OFS_RUN_CFG)
				nxt_auto = pwdata[PSG_BIT_AUTO];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			run_ff <= PSG_GATE_RST;
			sleep_ff <= PSG_GATE_RST;
			deep_ff <= PSG_GATE_RST;
			auto_ff <= PSG_AUTO_RST;
			rdata_ff <= PSG_ZERO;
			err_ff <= 1'b0;
		end
		else
		begin
			run_ff <= nxt_run;
			sleep_ff <= nxt_sleep;
			deep_ff <= nxt_deep;
			auto_ff <= nxt_auto;
			rdata_ff <= nxt_rdata;
			err_ff <= nxt_err;
		end
	end

	assign pready = 1'b1;
	assign prdata = rdata_ff;
	assign pslverr = psel && penable && err_ff;

	////////////////////////////////////////////////////////////////////////////
	// Deep sleep outranks sleep when both are reported
	assign gif.run_gate = run_ff;
	assign gif.sleep_gate = sleep_ff;
	assign gif.deep_gate = deep_ff;
	assign gif.auto_en = auto_ff;
	// An if chain keeps the enum typed, a conditional operator would not
	always_comb
	begin
		if (deep_sleep_now)
			gif.mode = PSG_DEEP;
		else if (sleep_now)
			gif.mode = PSG_SLEEP;
		else
			gif.mode = PSG_RUN;
	end

	psg_gate_select u_sel
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.gif(gif)
	);

	assign port_clk_en = gif.eff_gate;

	////////////////////////////////////////////////////////////////////////////
	// A request touching any unclocked port is refused as a whole
	always_comb
	begin
		nxt_ok = 1'b0;
		nxt_fault = 1'b0;
		if (port_req)
		begin
			if ((port_req_sel & ~gif.eff_gate) != PSG_GATE_RST)
				nxt_fault = 1'b1;
			else
				nxt_ok = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ok_ff <= 1'b0;
			fault_ff <= 1'b0;
		end
		else
		begin
			ok_ff <= nxt_ok;
			fault_ff <= nxt_fault;
		end
	end

	assign port_req_ok = ok_ff;
	assign port_req_fault = fault_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	property p_bit_order;
		(wr_acc && paddr == PSG_OFS_DEEP_GATE)
			|=> deep_ff == $past(pwdata[PSG_BIT_PORT_E:PSG_BIT_PORT_A]);
	endproperty
	a_bit_order: assert property (p_bit_order)
		else $error("Deep gate bits not taken from write data bits 4 to 0");

	property p_deep_on;
		(deep_sleep_now && !sys_rst) ##1 deep_sleep_now |-> port_clk_en == $past(deep_ff);
	endproperty
	a_deep_on: assert property (p_deep_on)
		else $error("Deep sleep clock enables differ from deep gate register");

	property p_gated_off;
		$past(deep_sleep_now) |-> (port_clk_en & ~$past(deep_ff)) == PSG_GATE_RST;
	endproperty
	a_gated_off: assert property (p_gated_off)
		else $error("Clock delivered to a port whose deep gate bit is clear");

	property p_fault;
		port_req |=> (port_req_fault
			== (($past(port_req_sel) & ~$past(port_clk_en)) != PSG_GATE_RST))
			&& (port_req_ok != port_req_fault);
	endproperty
	a_fault: assert property (p_fault)
		else $error("Port access answer does not match the clock gates");

	property p_readback;
		(setup && !pwrite && paddr == PSG_OFS_DEEP_GATE)
			|=> prdata == {27'h0000000, $past(deep_ff)};
	endproperty
	a_readback: assert property (p_readback)
		else $error("Deep gate register read back wrongly");

	property p_run_mode;
		(!sleep_now && !deep_sleep_now) |=> port_clk_en == $past(run_ff);
	endproperty
	a_run_mode: assert property (p_run_mode)
		else $error("Run mode does not use the run gate register");

	property p_sleep_auto;
		(sleep_now && !deep_sleep_now)
			|=> port_clk_en == ($past(auto_ff) ? $past(sleep_ff) : $past(run_ff));
	endproperty
	a_sleep_auto: assert property (p_sleep_auto)
		else $error("Sleep gate set used without automatic gating");

	property p_reserved;
		(psel && penable && !pwrite) |-> prdata[PSG_DATA_W-1:PSG_PORTS] == 27'h0000000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved bits read nonzero");
endmodule

// ### core/psg_pkg.sv
// Constants and types for the deep-sleep port clock gate block
package psg_pkg;
	localparam int PSG_PORTS = 5;
	localparam int PSG_ADDR_W = 12;
	localparam int PSG_DATA_W = 32;
	localparam logic [PSG_ADDR_W-1:0] PSG_OFS_RUN_GATE = 12'h108;
	localparam logic [PSG_ADDR_W-1:0] PSG_OFS_SLEEP_GATE = 12'h118;
	localparam logic [PSG_ADDR_W-1:0] PSG_OFS_DEEP_GATE = 12'h128;
	localparam logic [PSG_ADDR_W-1:0] PSG_OFS_RUN_CFG = 12'h060;
	localparam int PSG_BIT_AUTO = 0;
	localparam int PSG_BIT_PORT_A = 0;
	localparam int PSG_BIT_PORT_E = 4;
	localparam logic [PSG_PORTS-1:0] PSG_GATE_RST = 5'h00;
	localparam logic [PSG_DATA_W-1:0] PSG_ZERO = 32'h0000_0000;
	localparam logic PSG_AUTO_RST = 1'b0;
	typedef enum logic [1:0] {PSG_RUN, PSG_SLEEP, PSG_DEEP} psg_mode_e;
	typedef logic [PSG_PORTS-1:0] psg_gate_t;
endpackage

// ### core/psg_gate_if.sv
// Gate settings passed from the register file to the mode selector
`timescale 1ns/1ps
interface psg_gate_if;
	import psg_pkg::*;
	psg_gate_t run_gate;
	psg_gate_t sleep_gate;
	psg_gate_t deep_gate;
	logic auto_en;
	psg_mode_e mode;
	psg_gate_t eff_gate;
	modport regs (output run_gate, sleep_gate, deep_gate, auto_en, mode, input eff_gate);
	modport sel (input run_gate, sleep_gate, deep_gate, auto_en, mode, output eff_gate);
endinterface

// ### core/psg_gate_select.sv
// Picks the gate set for the present power mode, the run set in sleep when automatic gating is off
`timescale 1ns/1ps
module psg_gate_select
	import psg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Gate settings
	psg_gate_if.sel gif
);
	psg_gate_t eff_ff;
	psg_gate_t nxt_eff;

	always_comb
	begin
		nxt_eff = gif.run_gate;
		case (gif.mode)
			PSG_SLEEP:
			begin
				// Without automatic gating the sleep set is ignored
				if (gif.auto_en)
					nxt_eff = gif.sleep_gate;
			end
			PSG_DEEP:
			begin
				nxt_eff = gif.deep_gate;
			end
			default:
			begin
				nxt_eff = gif.run_gate;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			eff_ff <= PSG_GATE_RST;
		else
			eff_ff <= nxt_eff;
	end

	assign gif.eff_gate = eff_ff;
endmodule

// ### tb/psg_port_clock_gate_test.sv
// Self-checking bench for the deep-sleep port clock gate
`timescale 1ns/1ps
module psg_port_clock_gate_test
	import psg_pkg::*;
;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [PSG_ADDR_W-1:0] paddr = '0;
	logic [PSG_DATA_W-1:0] pwdata = '0;
	logic [PSG_DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic sleep_now = 1'b0;
	logic deep_sleep_now = 1'b0;
	logic [PSG_PORTS-1:0] port_clk_en;
	logic port_req = 1'b0;
	logic [PSG_PORTS-1:0] port_req_sel = '0;
	logic port_req_ok;
	logic port_req_fault;
	int num_errors = 0;
	int compares = 0;

	always #5 clk_sys = ~clk_sys;

	psg_port_clock_gate dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_now(sleep_now),
		.deep_sleep_now(deep_sleep_now), .port_clk_en(port_clk_en), .port_req(port_req),
		.port_req_sel(port_req_sel), .port_req_ok(port_req_ok), .port_req_fault(port_req_fault));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask

	task automatic complete_run();
		$display("compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One idle edge first, so a release and the next setup never share a time step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Wait states are left to the watchdog, the master counts none itself
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		chk_bit(er, 1'b0);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		chk_word(rd, exp);
		chk_bit(er, experr);
	endtask

	// Enables follow a mode or register change one edge later
	task automatic gate_chk(input logic [4:0] exp);
		repeat (2) @(posedge clk_sys);
		chk_word({27'h0, port_clk_en}, {27'h0, exp});
	endtask

	task automatic preq(input logic [4:0] sel, input logic exp_ok);
		port_req <= 1'b1;
		port_req_sel <= sel;
		@(posedge clk_sys);
		port_req <= 1'b0;
		@(posedge clk_sys);
		chk_bit(port_req_ok, exp_ok);
		chk_bit(port_req_fault, !exp_ok);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		sys_rst <= 1'b1;
		sleep_now <= 1'b0;
		deep_sleep_now <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk(PSG_OFS_DEEP_GATE, 32'h0000_0000, 1'b0);
		rd_chk(PSG_OFS_RUN_CFG, 32'h0000_0000, 1'b0);
		gate_chk(5'h00);
		preq(5'h01, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_deep();
		wr_reg(PSG_OFS_DEEP_GATE, 32'hFFFF_FFFF);
		rd_chk(PSG_OFS_DEEP_GATE, 32'h0000_001F, 1'b0);
		wr_reg(PSG_OFS_DEEP_GATE, 32'h0000_000A);
		rd_chk(PSG_OFS_DEEP_GATE, 32'h0000_000A, 1'b0);
		gate_chk(5'h0A);
		preq(5'h02, 1'b1);
		preq(5'h01, 1'b0);
		preq(5'h0A, 1'b1);
		preq(5'h1A, 1'b0);
		$display("test deep done");
	endtask

	task automatic t_modes();
		deep_sleep_now <= 1'b0;
		wr_reg(PSG_OFS_RUN_GATE, 32'h0000_0015);
		wr_reg(PSG_OFS_SLEEP_GATE, 32'hFFFF_FFE3);
		rd_chk(PSG_OFS_SLEEP_GATE, 32'h0000_0003, 1'b0);
		gate_chk(5'h15);
		sleep_now <= 1'b1;
		gate_chk(5'h15);
		wr_reg(PSG_OFS_RUN_CFG, 32'hFFFF_FFFF);
		rd_chk(PSG_OFS_RUN_CFG, 32'h0000_0001, 1'b0);
		gate_chk(5'h03);
		preq(5'h04, 1'b0);
		deep_sleep_now <= 1'b1;
		gate_chk(5'h0A);
		rd_chk(12'h7FC, 32'h0000_0000, 1'b1);
		wr_reg(PSG_OFS_RUN_CFG, 32'h0000_0000);
		deep_sleep_now <= 1'b0;
		gate_chk(5'h15);
		$display("test modes done");
	endtask

	initial
	begin
		t_reset();
		t_deep();
		t_modes();
		t_reset();
		complete_run();
	end

	initial
	begin
		#50000;
		num_errors++;
		complete_run();
	end
endmodule
